// ===== verilog/pio_host.sv
`timescale 1ns/1ps
// How it works
// - Whole cycle meets mode's minimum cycle time
// - Strobe held for mode's minimum active width
// - Strobe negated for minimum recovery time
// - Cycle is active plus inactive; all met
// - Stretch recovery to reach device-reported cycle
// - Sample ready after setup; wait while low
// - Modes 5 and 6 ignore ready
// - Wide indication honoured only in modes 0-2
// - Address is two chip selects plus three bits
// - Write strobe may end once wait rises
// - Read strobe may end once ready rises
module pio_host #(
    parameter int DW = 16          // Data width
) (
    // Clock and reset
    input  wire logic          clk_sys,
    input  wire logic          rstn,
    // Configuration
    input  wire logic [2:0]    pioMode,      // PIO mode 0..6
    input  wire logic [5:0]    minCycCyc,    // Device-reported cycle, clocks
    // Request side
    input  wire logic          reqValid,
    output logic               reqReady,
    input  wire logic          reqWrite,
    input  wire logic          reqByte,      // 8-bit register access
    input  wire logic          reqCtl,       // Control block select
    input  wire logic [2:0]    reqAddr,
    input  wire logic [DW-1:0] reqData,
    // Read answer side
    output logic               rspValid,
    input  wire logic          rspReady,
    output logic [DW-1:0]      rspData,
    output logic               rspWide,      // Card claimed 16-bit cycle, modes 0-2 only
    output logic               rspTimeout,   // Ready held past limit
    // Pins toward the card
    output logic               chipSelCmd_n,
    output logic               chipSelCtl_n,
    output logic [2:0]         pinAddr,
    output logic               ioReadStrobe_n,
    output logic               ioWriteStrobe_n,
    input  wire logic [DW-1:0] dataIn,
    output logic [DW-1:0]      dataOut,
    output logic               dataOe_n,     // Low while host drives
    input  wire logic          pioReady,
    input  wire logic          wideTransferInd_n
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic rdyMeta_ff, rdySync_ff;           // Ready two-flop chain
    logic wideMeta_ff, wideSync_ff;         // Wide indication chain
    logic [DW-1:0] dinMeta_ff, dinSync_ff;  // Read data chain

    // Every pin passes two flops before use
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            rdyMeta_ff  <= 1'b1;
            rdySync_ff  <= 1'b1;
            wideMeta_ff <= 1'b1;
            wideSync_ff <= 1'b1;
            dinMeta_ff  <= '0;
            dinSync_ff  <= '0;
        end
        else
        begin
            rdyMeta_ff  <= pioReady;
            rdySync_ff  <= rdyMeta_ff;
            wideMeta_ff <= wideTransferInd_n;
            wideSync_ff <= wideMeta_ff;
            dinMeta_ff  <= dataIn;
            dinSync_ff  <= dinMeta_ff;
        end
    end

    // ------------------------------------------------------------
    // Per-mode phase lengths
    // ------------------------------------------------------------
    logic [5:0] setCyc, actCyc, recCyc, hldCyc, cycCyc;
    logic       useRdy, useWide;
    logic [2:0] md;
    logic       reqByteQ_ff;                // Latched 8-bit access flag

    // Clamp illegal modes to the slowest one
    always_comb
    begin
        md      = (pioMode > 3'h6) ? 3'h0 : pioMode;
        setCyc  = pio_pkg::cyc_up(pio_pkg::SET_NS[md]);
        actCyc  = pio_pkg::cyc_up(reqByteQ_ff ? pio_pkg::ACT8_NS[md]
                                              : pio_pkg::ACT_NS[md]);
        recCyc  = pio_pkg::cyc_up(pio_pkg::REC_NS[md]);
        hldCyc  = pio_pkg::cyc_up(pio_pkg::HLD_NS[md]);
        cycCyc  = pio_pkg::cyc_up(pio_pkg::CYC_NS[md]);
        if (minCycCyc > cycCyc)
        begin
            cycCyc = minCycCyc;
        end
        useRdy  = (md < 3'(pio_pkg::RDY_FIRST_NA));
        useWide = (md <= 3'(pio_pkg::WIDE_LAST_MODE));
    end

    // ------------------------------------------------------------
    // Request latch and two-entry answer buffer
    // ------------------------------------------------------------
    pio_pkg::pio_state_t state_ff;
    logic          reqWriteQ_ff, reqCtlQ_ff;
    logic [2:0]    reqAddrQ_ff;
    logic [DW-1:0] reqDataQ_ff;
    logic [1:0]    bufCnt_ff;               // Entries held
    logic          bufWr, bufRd;
    logic [DW:0]   bufMem_ff [2];           // Data plus wide flag
    logic          bufHead_ff;
    logic          pushRd;                  // Read word completes

    // Refuse new cycles unless a read word has room
    assign reqReady = (state_ff == pio_pkg::PIO_IDLE) && (bufCnt_ff != 2'h2);
    assign bufWr    = pushRd;
    assign bufRd    = rspValid && rspReady;
    assign rspValid = (bufCnt_ff != 2'h0);

    // Latch request; address stays put for the whole cycle
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            reqWriteQ_ff <= 1'b0;
            reqByteQ_ff  <= 1'b0;
            reqCtlQ_ff   <= 1'b0;
            reqAddrQ_ff  <= 3'h0;
            reqDataQ_ff  <= '0;
        end
        else if (reqValid && reqReady)
        begin
            reqWriteQ_ff <= reqWrite;
            reqByteQ_ff  <= reqByte;
            reqCtlQ_ff   <= reqCtl;
            reqAddrQ_ff  <= reqAddr;
            reqDataQ_ff  <= reqData;
        end
    end

    // Buffer storage; a stalled reader loses no word
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            bufCnt_ff   <= 2'h0;
            bufHead_ff  <= 1'b0;
            bufMem_ff[0] <= '0;
            bufMem_ff[1] <= '0;
        end
        else
        begin
            if (bufWr)
            begin
                bufMem_ff[bufHead_ff ^ bufCnt_ff[0]] <=
                    {useWide && !wideSync_ff, dinSync_ff};
            end
            if (bufRd)
            begin
                bufHead_ff <= ~bufHead_ff;
            end
            bufCnt_ff <= bufCnt_ff + 2'(bufWr) - 2'(bufRd);
        end
    end
    assign rspData = bufMem_ff[bufHead_ff][DW-1:0];
    assign rspWide = bufMem_ff[bufHead_ff][DW];

    // ------------------------------------------------------------
    // Cycle sequencer
    // ------------------------------------------------------------
    logic [5:0] phCnt_ff;                   // Clocks in current phase; hold and recovery share one count
    logic [5:0] totCnt_ff;                  // Clocks since strobe fell
    logic [5:0] waitCnt_ff;                 // Clocks ready seen low
    logic       waited_ff;                  // Cycle extended by ready
    logic       rdyOk, actDone, timeout;
    logic       smpDone;                    // Ready and read data seen

    // Ready is sampled after setup plus synchroniser latency
    assign rdyOk   = !useRdy || rdySync_ff
                     || (phCnt_ff < pio_pkg::RDYSU_CYC + pio_pkg::SYNC_LAT);
    assign timeout = waitCnt_ff >= pio_pkg::RDYMAX_CYC + pio_pkg::SYNC_LAT;
    // Strobe may not end before ready is looked at; a read also waits
    // out the data synchroniser so that no stale word is captured
    assign smpDone = useRdy
                     ? (phCnt_ff >= pio_pkg::RDYSU_CYC + pio_pkg::SYNC_LAT)
                     : (reqWriteQ_ff || phCnt_ff >= pio_pkg::SYNC_LAT);
    assign actDone = (phCnt_ff + 6'h01 >= actCyc) && smpDone
                     && (rdyOk || timeout);
    assign pushRd  = (state_ff == pio_pkg::PIO_ACTIVE) && actDone
                     && !reqWriteQ_ff;

    // Phase walk: setup, active, hold, recovery
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            state_ff   <= pio_pkg::PIO_IDLE;
            phCnt_ff   <= 6'h00;
            totCnt_ff  <= 6'h00;
            waitCnt_ff <= 6'h00;
            waited_ff  <= 1'b0;
            rspTimeout <= 1'b0;
        end
        else
        begin
            phCnt_ff  <= phCnt_ff + 6'h01;
            totCnt_ff <= (totCnt_ff == 6'h3F) ? totCnt_ff
                                              : totCnt_ff + 6'h01;
            unique case (state_ff)
                pio_pkg::PIO_IDLE:
                begin
                    phCnt_ff <= 6'h00;
                    if (reqValid && reqReady)
                    begin
                        state_ff <= pio_pkg::PIO_SETUP;
                    end
                end
                pio_pkg::PIO_SETUP:
                begin
                    // Address settles before strobe
                    if (phCnt_ff >= setCyc)
                    begin
                        state_ff   <= pio_pkg::PIO_ACTIVE;
                        phCnt_ff   <= 6'h00;
                        totCnt_ff  <= 6'h00;
                        waitCnt_ff <= 6'h00;
                        waited_ff  <= 1'b0;
                    end
                end
                pio_pkg::PIO_ACTIVE:
                begin
                    // Low ready past the sample point stretches it
                    if (!rdyOk)
                    begin
                        waited_ff  <= 1'b1;
                        waitCnt_ff <= waitCnt_ff + 6'h01;
                    end
                    // Strobe ends once ready is back
                    if (actDone)
                    begin
                        state_ff   <= pio_pkg::PIO_HOLD;
                        phCnt_ff   <= 6'h00;
                        rspTimeout <= timeout;
                    end
                end
                pio_pkg::PIO_HOLD:
                begin
                    if (phCnt_ff + 6'h01 >= hldCyc)
                    begin
                        state_ff <= pio_pkg::PIO_RECOV;
                    end
                end
                pio_pkg::PIO_RECOV:
                begin
                    // Inactive plus active must reach total
                    if ((phCnt_ff + 6'h01 >= recCyc)
                        && (totCnt_ff + 6'h01 >= cycCyc))
                    begin
                        state_ff <= pio_pkg::PIO_IDLE;
                    end
                end
                default:
                begin
                    state_ff <= pio_pkg::PIO_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pin drivers, all registered
    // ------------------------------------------------------------
    // Selects and address only move while both strobes are high
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            chipSelCmd_n    <= 1'b1;
            chipSelCtl_n    <= 1'b1;
            pinAddr         <= 3'h0;
            ioReadStrobe_n  <= 1'b1;
            ioWriteStrobe_n <= 1'b1;
            dataOut         <= '0;
            dataOe_n        <= 1'b1;
        end
        else
        begin
            chipSelCmd_n <= !(state_ff != pio_pkg::PIO_IDLE && !reqCtlQ_ff);
            chipSelCtl_n <= !(state_ff != pio_pkg::PIO_IDLE && reqCtlQ_ff);
            pinAddr      <= reqAddrQ_ff;
            // Strobe low exactly while in active state
            // Selects lead the strobe by a full setup time
            if (state_ff == pio_pkg::PIO_SETUP && phCnt_ff >= setCyc)
            begin
                ioReadStrobe_n  <= reqWriteQ_ff;
                ioWriteStrobe_n <= !reqWriteQ_ff;
            end
            else if (state_ff == pio_pkg::PIO_ACTIVE && actDone)
            begin
                ioReadStrobe_n  <= 1'b1;
                ioWriteStrobe_n <= 1'b1;
            end
            // Write data spans setup through hold
            dataOut  <= reqDataQ_ff;
            dataOe_n <= !(reqWriteQ_ff && state_ff != pio_pkg::PIO_IDLE
                          && state_ff != pio_pkg::PIO_RECOV);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_strobe_min;
        @(posedge clk_sys) disable iff (!rstn)
        $fell(ioReadStrobe_n) |-> !ioReadStrobe_n [*2];
    endproperty
    a_strobe_min: assert property (p_strobe_min)
        else $error("read strobe shorter than minimum");

    property p_excl;
        @(posedge clk_sys) disable iff (!rstn)
        !(!ioReadStrobe_n && !ioWriteStrobe_n);
    endproperty
    a_excl: assert property (p_excl)
        else $error("both strobes active");

    property p_addr_stable;
        @(posedge clk_sys) disable iff (!rstn)
        !ioWriteStrobe_n |-> $stable(pinAddr) && !dataOe_n;
    endproperty
    a_addr_stable: assert property (p_addr_stable)
        else $error("address or data moved under strobe");

    property p_rec;
        @(posedge clk_sys) disable iff (!rstn)
        $rose(ioWriteStrobe_n) |=> ioWriteStrobe_n;
    endproperty
    a_rec: assert property (p_rec)
        else $error("recovery too short");

    property p_total;
        @(posedge clk_sys) disable iff (!rstn)
        (state_ff == pio_pkg::PIO_RECOV && $past(state_ff)
         == pio_pkg::PIO_RECOV) |-> ##[0:63] state_ff == pio_pkg::PIO_IDLE;
    endproperty
    a_total: assert property (p_total)
        else $error("recovery never ends");

    property p_wait;
        @(posedge clk_sys) disable iff (!rstn)
        (state_ff == pio_pkg::PIO_ACTIVE && !rdyOk && !timeout)
        |=> state_ff == pio_pkg::PIO_ACTIVE;
    endproperty
    a_wait: assert property (p_wait)
        else $error("cycle closed while ready low");

    property p_nordy;
        @(posedge clk_sys) disable iff (!rstn)
        (pioMode >= 3'h5 && pioMode <= 3'h6) |-> rdyOk;
    endproperty
    a_nordy: assert property (p_nordy)
        else $error("ready used in mode 5 or 6");

    property p_wide;
        @(posedge clk_sys) disable iff (!rstn)
        (pushRd && pioMode > 3'h2 && pioMode <= 3'h6) |=>
            !bufMem_ff[$past(bufHead_ff ^ bufCnt_ff[0])][DW];
    endproperty
    a_wide: assert property (p_wide)
        else $error("wide flag kept in fast mode");
endmodule : pio_host

// ===== include/pio_pkg.sv
package pio_pkg;
    // ------------------------------------------------------------
    // Clock and timing figures (nanoseconds as printed)
    // ------------------------------------------------------------
    localparam int CLK_NS = 40;              // 25 MHz system clock
    localparam int NMODES = 7;               // PIO modes 0..6
    // Minimum total cycle per mode
    localparam int CYC_NS [NMODES] = '{600, 383, 240, 180, 120, 100, 80};
    // Minimum active strobe, 16-bit data
    localparam int ACT_NS [NMODES] = '{165, 125, 100, 80, 70, 65, 55};
    // Minimum active strobe, 8-bit register access
    localparam int ACT8_NS[NMODES] = '{290, 290, 290, 80, 70, 65, 55};
    // Minimum recovery; none printed for modes 0..2
    localparam int REC_NS [NMODES] = '{0, 0, 0, 70, 25, 25, 20};
    // Address setup before strobe and hold after it
    localparam int SET_NS [NMODES] = '{70, 50, 30, 30, 25, 15, 10};
    localparam int HLD_NS [NMODES] = '{20, 15, 10, 10, 10, 10, 10};
    localparam int RDYSU_NS = 35;            // Ready sampling point
    localparam int RDYMAX_NS = 1250;         // Longest ready-low pulse
    localparam int WIDE_LAST_MODE = 2;       // Wide indication valid
    localparam int RDY_FIRST_NA = 5;         // No ready wait from here

    // Round a least time up to whole cycles, at least one
    function automatic logic [5:0] cyc_up(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        if (c < 1)
        begin
            c = 1;
        end
        return c[5:0];
    endfunction : cyc_up

    localparam logic [5:0] RDYSU_CYC  = cyc_up(RDYSU_NS);
    // Longest time rounds down
    localparam logic [5:0] RDYMAX_CYC = 6'(RDYMAX_NS / CLK_NS);
    localparam logic [5:0] SYNC_LAT   = 6'h02; // Ready synchroniser depth

    // Sequencer states
    typedef enum logic [2:0] {
        PIO_IDLE = 3'b000,
        PIO_SETUP = 3'b001,
        PIO_ACTIVE = 3'b010,
        PIO_HOLD = 3'b011,
        PIO_RECOV = 3'b100
    } pio_state_t;
endpackage : pio_pkg

// ===== tb/pio_card_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Card side of the PIO port, with timing observers
// ------------------------------------------------------------
module pio_card_model (
    // Clock and reset, for measurement, ready timing and the last-word register
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    // Scenario knobs
    input  wire logic [5:0]  waitClks,
    input  wire logic        wideEn,
    input  wire logic [15:0] rdBase,
    // Host pins
    input  wire logic        chipSelCmd_n,
    input  wire logic        chipSelCtl_n,
    input  wire logic [2:0]  pinAddr,
    input  wire logic        ioReadStrobe_n,
    input  wire logic        ioWriteStrobe_n,
    input  wire logic [15:0] dataOut,
    input  wire logic        dataOe_n,
    output logic [15:0]      dataIn,
    output logic             pioReady,
    output logic             wideTransferInd_n,
    // Observations, in clocks and values
    output logic [7:0]       actLen,
    output logic [7:0]       recLen,
    output logic [7:0]       cycLen,
    output logic [15:0]      wrData,
    output logic [3:0]       fallAddr,
    output logic [3:0]       riseAddr,
    output logic             wrOeOk
);
    logic        strobe_n;  // Either strobe low
    logic        strbDly;   // Strobe seen at last edge
    logic        wrDly;     // Write strobe seen at last edge
    logic [7:0]  lowCnt;    // Edges with strobe low
    logic [7:0]  highCnt;   // Edges with strobe high
    logic [7:0]  sinceFall; // Edges since last fall
    logic [3:0]  curAddr;   // Block select and address
    logic [15:0] lastDrv;   // Last word put on the bus
    assign strobe_n = ioReadStrobe_n & ioWriteStrobe_n;
    assign curAddr = {~chipSelCtl_n, pinAddr};
    // Low from the strobe edge on, so well before the sample point
    assign pioReady = strobe_n || (lowCnt >= 8'(waitClks));
    // Data valid for the whole strobe; released bus shows a wrong word
    assign dataIn = !ioReadStrobe_n ? (rdBase ^ {12'h000, curAddr})
                                    : ~lastDrv;
    // Wide claim on any selected address; host must filter by mode
    assign wideTransferInd_n = !(wideEn && !(chipSelCmd_n & chipSelCtl_n));
    // Phase lengths, taken at each strobe edge
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            {strbDly, wrDly} <= 2'b11;
            {lowCnt, highCnt, sinceFall} <= '0;
            {actLen, recLen, cycLen} <= '0;
            {wrData, fallAddr, riseAddr, wrOeOk, lastDrv} <= '0;
        end
        else
        begin
            strbDly <= strobe_n;
            wrDly <= ioWriteStrobe_n;
            lowCnt <= strobe_n ? 8'h00 : lowCnt + 8'h01;
            highCnt <= strobe_n ? highCnt + 8'h01 : 8'h00;
            sinceFall <= sinceFall + 8'h01;
            if (!ioReadStrobe_n)
                lastDrv <= dataIn;
            // Any legal mix of stretched phases is accepted
            if (!strobe_n && strbDly)
            begin
                recLen <= highCnt;
                cycLen <= sinceFall;
                sinceFall <= 8'h01;
                fallAddr <= curAddr;
            end
            if (strobe_n && !strbDly)
            begin
                actLen <= lowCnt;
                riseAddr <= curAddr;
            end
            // Write word as seen just after the strobe rises
            if (ioWriteStrobe_n && !wrDly)
            begin
                wrData <= dataOut;
                wrOeOk <= !dataOe_n;
            end
        end
    end
endmodule : pio_card_model

// ===== tb/ide_pio_io_cycle_timing_tb.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Host PIO sequencer against the card model
// ------------------------------------------------------------
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
    n_errors++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module ide_pio_io_cycle_timing_tb;
    logic clk_sys = 1'b0;
    logic rstn, reqValid, reqWrite, reqByte, reqCtl, rspReady, wideEn;
    logic reqReady, rspValid, rspWide, rspTimeout, dataOe_n;
    logic chipSelCmd_n, chipSelCtl_n, ioReadStrobe_n, ioWriteStrobe_n;
    logic pioReady, wideTransferInd_n, wrOeOk;
    logic [2:0]  pioMode, reqAddr, pinAddr;
    logic [5:0]  minCycCyc, waitClks;
    logic [15:0] reqData, rspData, dataIn, dataOut, rdBase, wrData;
    logic [7:0]  actLen, recLen, cycLen;
    logic [3:0]  fallAddr, riseAddr;
    int n_errors = 0;
    int n_tests = 0;
    // 25 MHz clock
    always #20 clk_sys = ~clk_sys;
    pio_host #(.DW(16)) dut_u (.clk_sys(clk_sys), .rstn(rstn),
        .pioMode(pioMode), .minCycCyc(minCycCyc), .reqValid(reqValid),
        .reqReady(reqReady), .reqWrite(reqWrite), .reqByte(reqByte),
        .reqCtl(reqCtl), .reqAddr(reqAddr), .reqData(reqData),
        .rspValid(rspValid), .rspReady(rspReady), .rspData(rspData),
        .rspWide(rspWide), .rspTimeout(rspTimeout),
        .chipSelCmd_n(chipSelCmd_n), .chipSelCtl_n(chipSelCtl_n),
        .pinAddr(pinAddr), .ioReadStrobe_n(ioReadStrobe_n),
        .ioWriteStrobe_n(ioWriteStrobe_n), .dataIn(dataIn),
        .dataOut(dataOut), .dataOe_n(dataOe_n), .pioReady(pioReady),
        .wideTransferInd_n(wideTransferInd_n));
    pio_card_model card_u (.clk_sys(clk_sys), .rstn(rstn),
        .waitClks(waitClks), .wideEn(wideEn), .rdBase(rdBase),
        .chipSelCmd_n(chipSelCmd_n), .chipSelCtl_n(chipSelCtl_n),
        .pinAddr(pinAddr), .ioReadStrobe_n(ioReadStrobe_n),
        .ioWriteStrobe_n(ioWriteStrobe_n), .dataOut(dataOut),
        .dataOe_n(dataOe_n), .dataIn(dataIn), .pioReady(pioReady),
        .wideTransferInd_n(wideTransferInd_n), .actLen(actLen),
        .recLen(recLen), .cycLen(cycLen), .wrData(wrData),
        .fallAddr(fallAddr), .riseAddr(riseAddr), .wrOeOk(wrOeOk));
    // Least time in whole clocks, rounded up
    function automatic int clks(input int ns);
        return (ns + 39) / 40;
    endfunction : clks
    task automatic conclude();
        $display("Tests %0d, errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude
    // Hold the request until the edge that takes it
    task automatic issue(input logic w, b, c, input logic [2:0] a,
                         input logic [15:0] d);
        bit ok;
        ok = 0;
        reqValid <= 1'b1;
        {reqWrite, reqByte, reqCtl, reqAddr, reqData} <= {w, b, c, a, d};
        for (int i = 0; i < 200 && !ok; i++)
        begin
            #1 ok = (reqReady === 1'b1);
            @(posedge clk_sys);
        end
        reqValid <= 1'b0;
        @(posedge clk_sys);
        if (!ok)
        begin
            n_errors++;
            conclude();
        end
    endtask : issue
    // Idle again once recovery is over
    task automatic waitIdle();
        bit ok;
        ok = 0;
        for (int i = 0; i < 200 && !ok; i++)
        begin
            #1 ok = (reqReady === 1'b1);
            @(posedge clk_sys);
        end
        if (!ok)
        begin
            n_errors++;
            conclude();
        end
    endtask : waitIdle
    // Word is taken at the edge that pops it
    task automatic getRsp(input logic [15:0] e, input logic w);
        bit ok;
        logic [16:0] got;
        ok = 0;
        got = '0;
        for (int i = 0; i < 200 && !ok; i++)
        begin
            #1 ok = (rspValid === 1'b1);
            got = {rspWide, rspData};
            @(posedge clk_sys);
        end
        if (!ok)
        begin
            n_errors++;
            conclude();
        end
        `CHK("rspData", e, got[15:0])
        `CHK("rspWide", w, got[16])
    endtask : getRsp
    task automatic t_reset();
        #1;
        `CHK("strobes", 2'b11, {ioReadStrobe_n, ioWriteStrobe_n})
        `CHK("selects", 2'b11, {chipSelCmd_n, chipSelCtl_n})
        `CHK("dataOe_n", 1'b1, dataOe_n)
        `CHK("rspValid", 1'b0, rspValid)
        @(posedge clk_sys);
    endtask : t_reset
    // Every mode: back-to-back writes then a read
    task automatic t_modes();
        logic b;
        logic [2:0] a;
        for (int m = 0; m < 7; m++)
        begin
            b = (m < 3);
            a = 3'(m) ^ 3'h5;
            pioMode <= 3'(m);
            issue(1'b1, 1'b0, 1'b0, 3'h1, 16'h1234);
            issue(1'b1, b, m[0], a, 16'h5A00 | 16'(m));
            waitIdle();
            `CHK("act", 1'b1, actLen >= clks(b ? pio_pkg::ACT8_NS[m] :
                 pio_pkg::ACT_NS[m]))
            `CHK("rec", 1'b1, recLen >= clks(pio_pkg::REC_NS[m]))
            `CHK("cyc", 1'b1, cycLen >= clks(pio_pkg::CYC_NS[m]))
            `CHK("wrData", 16'h5A00 | 16'(m), wrData)
            `CHK("wrOe", 1'b1, wrOeOk)
            `CHK("fallAddr", {m[0], a}, fallAddr)
            `CHK("riseAddr", {m[0], a}, riseAddr)
            issue(1'b0, 1'b0, 1'b1, a, 16'h0000);
            getRsp(rdBase ^ {12'h000, 1'b1, a}, m < 3);
            waitIdle();
            `CHK("rdAct", 1'b1, actLen >= clks(pio_pkg::ACT_NS[m]))
        end
    endtask : t_modes
    // Device-reported cycle longer than the mode's own
    task automatic t_stretch();
        pioMode <= 3'h6;
        minCycCyc <= 6'h14;
        issue(1'b1, 1'b0, 1'b0, 3'h2, 16'h00FF);
        issue(1'b1, 1'b0, 1'b0, 3'h3, 16'hFF00);
        waitIdle();
        `CHK("cycDev", 1'b1, cycLen >= 8'h14)
        minCycCyc <= 6'h00;
    endtask : t_stretch
    // Ready extension in a slow mode, ignored in a fast one
    task automatic t_wait();
        for (int m = 1; m < 7; m += 5)
        begin
            pioMode <= 3'(m);
            waitClks <= 6'h0C;
            issue(1'b0, 1'b0, 1'b0, 3'h6, 16'h0000);
            getRsp(rdBase ^ 16'h0006, m < 3);
            waitIdle();
            `CHK("waitAct", m < 5, actLen >= 8'h0C)
        end
        waitClks <= 6'h00;
    endtask : t_wait
    // Ready held low too long ends the cycle anyway
    task automatic t_timeout();
        pioMode <= 3'h3;
        waitClks <= 6'h32;
        issue(1'b0, 1'b0, 1'b0, 3'h4, 16'h0000);
        getRsp(rdBase ^ 16'h0004, 1'b0);
        `CHK("timeout", 1'b1, rspTimeout)
        waitIdle();
        `CHK("capAct", 1'b1, actLen < 8'h32)
        waitClks <= 6'h00;
        issue(1'b0, 1'b0, 1'b0, 3'h4, 16'h0000);
        getRsp(rdBase ^ 16'h0004, 1'b0);
        `CHK("noTimeout", 1'b0, rspTimeout)
        waitIdle();
    endtask : t_timeout
    // Stalled reader: buffer fills, host refuses, then drains in order
    task automatic t_buffer();
        bit seen;
        seen = 0;
        pioMode <= 3'h4;
        rspReady <= 1'b0;
        issue(1'b0, 1'b0, 1'b0, 3'h1, 16'h0000);
        issue(1'b0, 1'b0, 1'b0, 3'h2, 16'h0000);
        for (int i = 0; i < 100; i++)
        begin
            #1 seen |= (reqReady === 1'b1);
            @(posedge clk_sys);
        end
        `CHK("fullRefuse", 1'b0, seen)
        rspReady <= 1'b1;
        getRsp(rdBase ^ 16'h0001, 1'b0);
        getRsp(rdBase ^ 16'h0002, 1'b0);
        waitIdle();
    endtask : t_buffer
    initial
    begin
        {rstn, reqValid, reqWrite, reqByte, reqCtl, wideEn} = '0;
        {pioMode, reqAddr, minCycCyc, waitClks, reqData} = '0;
        rspReady = 1'b1;
        wideEn = 1'b1;
        rdBase = 16'hC3A0;
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        t_reset();
        t_modes();
        t_stretch();
        t_wait();
        t_timeout();
        t_buffer();
        conclude();
    end
endmodule : ide_pio_io_cycle_timing_tb
